// File: pcbs_regs.svh
`ifndef PCBS_REGS_SVH
`define PCBS_REGS_SVH

// ----------------------------------------
// Pad and cell layout.
// ----------------------------------------
`define PCBS_NUM_IO 4
`define PCBS_NUM_DED 1
`define PCBS_NUM_PAD 5
`define PCBS_CELLS_PER_PAD 3
`define PCBS_CELL_CTL 0
`define PCBS_CELL_OUT 1
`define PCBS_CELL_IN 2
`define PCBS_SAFE_TRIPLE 3'h1

// ----------------------------------------
// Instruction register and data registers.
// ----------------------------------------
`define PCBS_IR_LEN 5
`define PCBS_IR_CAPTURE 5'h01
`define PCBS_OP_EXTEST 5'h00
`define PCBS_OP_SAMPLE 5'h01
`define PCBS_OP_IDCODE 5'h09
`define PCBS_OP_BYPASS 5'h1F
`define PCBS_ID_LEN 32

`endif

// File: pcbs_pkg.sv
package pcbs_pkg;

   // ----------------------------------------
   // Connection mode of one pad, from the loaded configuration.
   // ----------------------------------------
   typedef enum logic [2:0] {
      PCBS_UNUSED,
      PCBS_INPUT,
      PCBS_OUTPUT,
      PCBS_TRISTATE,
      PCBS_BIDIR,
      PCBS_DIFF_P_IN,
      PCBS_DIFF_P_OUT,
      PCBS_DIFF_N
   } pcbs_mode_t;

   // ----------------------------------------
   // Test access port controller states.
   // ----------------------------------------
   typedef enum logic [3:0] {
      TLR, RTI,
      SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } pcbs_tap_state_t;

endpackage

// File: pcbs_tap_if.sv
`timescale 1ns/100ps
`include "pcbs_regs.svh"

interface pcbs_tap_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   pcbs_pkg::pcbs_tap_state_t state;
   logic [`PCBS_IR_LEN-1:0] ir;
   logic ir_tdo;

   modport tap (
      input tck_rise,
      input tck_fall,
      input tms,
      input tdi,
      output state,
      output ir,
      output ir_tdo
   );

   modport core (
      output tck_rise,
      output tck_fall,
      output tms,
      output tdi,
      input state,
      input ir,
      input ir_tdo
   );
endinterface

// File: pcbs_tap.sv
`timescale 1ns/100ps
`include "pcbs_regs.svh"

module pcbs_tap (
   // Clock and synchronised reset
   input wire logic clock,
   input wire logic rst_n,
   // Edges and levels of the test port
   pcbs_tap_if.tap bus
);

   logic [`PCBS_IR_LEN-1:0] ir_sh_q;

   function automatic pcbs_pkg::pcbs_tap_state_t nxt(input pcbs_pkg::pcbs_tap_state_t s, input logic m);
      unique case (s)
         pcbs_pkg::TLR: nxt = m ? pcbs_pkg::TLR : pcbs_pkg::RTI;
         pcbs_pkg::RTI: nxt = m ? pcbs_pkg::SEL_DR : pcbs_pkg::RTI;
         pcbs_pkg::SEL_DR: nxt = m ? pcbs_pkg::SEL_IR : pcbs_pkg::CAP_DR;
         pcbs_pkg::CAP_DR: nxt = m ? pcbs_pkg::EX1_DR : pcbs_pkg::SH_DR;
         pcbs_pkg::SH_DR: nxt = m ? pcbs_pkg::EX1_DR : pcbs_pkg::SH_DR;
         pcbs_pkg::EX1_DR: nxt = m ? pcbs_pkg::UPD_DR : pcbs_pkg::PAU_DR;
         pcbs_pkg::PAU_DR: nxt = m ? pcbs_pkg::EX2_DR : pcbs_pkg::PAU_DR;
         pcbs_pkg::EX2_DR: nxt = m ? pcbs_pkg::UPD_DR : pcbs_pkg::SH_DR;
         pcbs_pkg::UPD_DR: nxt = m ? pcbs_pkg::SEL_DR : pcbs_pkg::RTI;
         pcbs_pkg::SEL_IR: nxt = m ? pcbs_pkg::TLR : pcbs_pkg::CAP_IR;
         pcbs_pkg::CAP_IR: nxt = m ? pcbs_pkg::EX1_IR : pcbs_pkg::SH_IR;
         pcbs_pkg::SH_IR: nxt = m ? pcbs_pkg::EX1_IR : pcbs_pkg::SH_IR;
         pcbs_pkg::EX1_IR: nxt = m ? pcbs_pkg::UPD_IR : pcbs_pkg::PAU_IR;
         pcbs_pkg::PAU_IR: nxt = m ? pcbs_pkg::EX2_IR : pcbs_pkg::PAU_IR;
         pcbs_pkg::EX2_IR: nxt = m ? pcbs_pkg::UPD_IR : pcbs_pkg::SH_IR;
         pcbs_pkg::UPD_IR: nxt = m ? pcbs_pkg::SEL_DR : pcbs_pkg::RTI;
      endcase
   endfunction

   // ----------------------------------------
   // Controller state, advanced on each test clock rise.
   // ----------------------------------------
   // With no separate test reset pin, five rises with mode-select high reach reset from anywhere.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus.state <= pcbs_pkg::TLR;
      end else if (bus.tck_rise) begin
         bus.state <= nxt(bus.state, bus.tms);
      end
   end

   // ----------------------------------------
   // Instruction register.
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ir_sh_q <= `PCBS_IR_CAPTURE;
      end else if (bus.tck_rise && bus.state == pcbs_pkg::CAP_IR) begin
         ir_sh_q <= `PCBS_IR_CAPTURE;
      end else if (bus.tck_rise && bus.state == pcbs_pkg::SH_IR) begin
         ir_sh_q <= {bus.tdi, ir_sh_q[`PCBS_IR_LEN-1:1]};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus.ir <= `PCBS_OP_IDCODE;
      end else if (bus.state == pcbs_pkg::TLR) begin
         bus.ir <= `PCBS_OP_IDCODE;
      end else if (bus.tck_fall && bus.state == pcbs_pkg::UPD_IR) begin
         bus.ir <= ir_sh_q;
      end
   end

   assign bus.ir_tdo = ir_sh_q[0];

endmodule

// File: pcbs_top.sv
`timescale 1ns/100ps
`include "pcbs_regs.svh"

// Overview of operation
// - Each I/O block has control, output, input cells.
// - Each cell is shift stage plus update latch.
// - Input pins: control, output cells internal only.
// - Output pins keep input cell on pad.
// - Control safe value one disables output driver.
// - Unused pins fully connected, weak pull-down when disabled.
// - Differential pairs scanned through P-side cells only.
// - N-side cells stay in chain, unconnected.
// - N pin driven with complement of P output.
// - P-side differential input: only input cell connected.
// - P-side differential outputs keep all cells connected.
// - Instruction register five bits, captures ending 01.
// - Identification code register readable through port.
// - Port uses four pins; reset by mode-select.
// - Test clock up to 33 MHz, stoppable.
// - Dedicated pins keep full bidirectional scan.
// - Unconfigured: every user pad fully connected.

module pcbs_top #(
   // Value is arbitrary; bit zero must stay set.
   parameter logic [`PCBS_ID_LEN-1:0] ID_CODE = 32'h0A5C_E001
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Test access port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   // Loaded configuration
   input wire logic configured,
   input wire pcbs_pkg::pcbs_mode_t pin_mode [`PCBS_NUM_IO],
   // Core side of each pad, dedicated pins last
   input wire logic [`PCBS_NUM_PAD-1:0] core_out,
   input wire logic [`PCBS_NUM_PAD-1:0] core_oe_n,
   output logic [`PCBS_NUM_PAD-1:0] core_in,
   // Pads
   input wire logic [`PCBS_NUM_PAD-1:0] pad_in,
   output logic [`PCBS_NUM_PAD-1:0] pad_out,
   output logic [`PCBS_NUM_PAD-1:0] pad_oe_n,
   output logic [`PCBS_NUM_PAD-1:0] pad_pull0
);

   localparam int NP = `PCBS_NUM_PAD;
   localparam int NIO = `PCBS_NUM_IO;
   localparam int NC = `PCBS_CELLS_PER_PAD * NP;
   localparam int NS = NP + 3;
   localparam logic [NC-1:0] SAFE = {NP{`PCBS_SAFE_TRIPLE}};

   logic [1:0] rst_q;
   logic rst_n;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [NS-1:0] s3_q;
   logic [NS-1:0] lvl_q;
   logic [NP-1:0] pad_lvl;
   logic [NC-1:0] bsr_sh_q;
   logic [NC-1:0] bsr_up_q;
   logic [NC-1:0] cap_w;
   logic [`PCBS_ID_LEN-1:0] id_sh_q;
   logic byp_q;
   logic sel_bsr;
   logic sel_id;
   logic extest;
   logic [NP-1:0] base_o;
   logic [NP-1:0] base_oe_n;
   logic [NP-1:0] fin_o;
   logic [NP-1:0] fin_oe_n;
   logic [NP-1:0] pulls;
   pcbs_pkg::pcbs_mode_t mode_w [NP];

   pcbs_tap_if tap_bus();

   // ----------------------------------------
   // Decoding helpers.
   // ----------------------------------------
   function automatic logic is_bsr(input logic [`PCBS_IR_LEN-1:0] ir);
      is_bsr = (ir == `PCBS_OP_EXTEST) || (ir == `PCBS_OP_SAMPLE);
   endfunction

   // Control and output cells reach the driver.
   function automatic logic drives(input pcbs_pkg::pcbs_mode_t m);
      drives = !(m == pcbs_pkg::PCBS_INPUT || m == pcbs_pkg::PCBS_DIFF_P_IN || m == pcbs_pkg::PCBS_DIFF_N);
   endfunction

   // Input cell reaches the receiver.
   function automatic logic senses(input pcbs_pkg::pcbs_mode_t m);
      senses = (m != pcbs_pkg::PCBS_DIFF_N);
   endfunction

   // ----------------------------------------
   // Reset release.
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end

   assign rst_n = rst_q[1];

   // ----------------------------------------
   // Pin synchronisers: bit 0 test clock, 1 mode-select, 2 data-in, then pads.
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= {NS{1'b0}};
         s2_q <= {NS{1'b0}};
         s3_q <= {NS{1'b0}};
      end else begin
         s1_q <= {pad_in, tdi, tms, tck};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A level is accepted only once the last two stages agree.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q <= {NS{1'b0}};
      end else begin
         lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   // Edges come from the accepted level, so a clock parked high or low simply yields none.
   // Each test clock phase must last at least two system clocks, which 33 MHz meets.
   assign tap_bus.tck_rise = s2_q[0] & s3_q[0] & ~lvl_q[0];
   assign tap_bus.tck_fall = ~s2_q[0] & ~s3_q[0] & lvl_q[0];
   assign tap_bus.tms = lvl_q[1];
   assign tap_bus.tdi = lvl_q[2];
   assign pad_lvl = lvl_q[NS-1:3];

   // ----------------------------------------
   // Controller and instruction register.
   // ----------------------------------------
   pcbs_tap u_tap (
      .clock(clock),
      .rst_n(rst_n),
      .bus(tap_bus)
   );

   assign sel_bsr = is_bsr(tap_bus.ir);
   assign sel_id = (tap_bus.ir == `PCBS_OP_IDCODE);
   assign extest = (tap_bus.ir == `PCBS_OP_EXTEST);

   // ----------------------------------------
   // Per-pad connection of the three cells.
   // ----------------------------------------
   for (genvar p = 0; p < NP; p++) begin : g_pad
      localparam int CC = `PCBS_CELLS_PER_PAD * p + `PCBS_CELL_CTL;
      localparam int OC = `PCBS_CELLS_PER_PAD * p + `PCBS_CELL_OUT;
      localparam int IC = `PCBS_CELLS_PER_PAD * p + `PCBS_CELL_IN;

      if (p < NIO) begin : g_user
         // Before configuration every user pad behaves as an unused, fully connected pad.
         assign mode_w[p] = configured ? pin_mode[p] : pcbs_pkg::PCBS_UNUSED;
      end else begin : g_ded
         assign mode_w[p] = pcbs_pkg::PCBS_BIDIR;
      end

      // Cells that have lost their pad hold their shifted value through capture.
      assign cap_w[CC] = drives(mode_w[p]) ? core_oe_n[p] : bsr_sh_q[CC];
      assign cap_w[OC] = drives(mode_w[p]) ? core_out[p] : bsr_sh_q[OC];
      assign cap_w[IC] = senses(mode_w[p]) ? pad_lvl[p] : bsr_sh_q[IC];

      // A one in the control latch turns the driver off.
      assign base_oe_n[p] = ~drives(mode_w[p]) | (extest ? bsr_up_q[CC] : core_oe_n[p]);
      assign base_o[p] = extest ? bsr_up_q[OC] : core_out[p];

      if (p > 0) begin : g_pair
         // The N pad follows its P partner only; its own cells never reach it.
         always_comb begin
            if (mode_w[p] == pcbs_pkg::PCBS_DIFF_N) begin
               fin_oe_n[p] = (mode_w[p-1] == pcbs_pkg::PCBS_DIFF_P_OUT) ? base_oe_n[p-1] : 1'b1;
               fin_o[p] = ~base_o[p-1];
            end else begin
               fin_oe_n[p] = base_oe_n[p];
               fin_o[p] = base_o[p];
            end
         end
      end else begin : g_first
         assign fin_oe_n[p] = base_oe_n[p];
         assign fin_o[p] = base_o[p];
      end

      assign pulls[p] = (mode_w[p] == pcbs_pkg::PCBS_UNUSED) & fin_oe_n[p];
   end

   // ----------------------------------------
   // Boundary register: shift stage per cell, cell 0 nearest data-out.
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bsr_sh_q <= SAFE;
      end else if (tap_bus.tck_rise && sel_bsr) begin
         if (tap_bus.state == pcbs_pkg::CAP_DR) begin
            bsr_sh_q <= cap_w;
         end else if (tap_bus.state == pcbs_pkg::SH_DR) begin
            bsr_sh_q <= {tap_bus.tdi, bsr_sh_q[NC-1:1]};
         end
      end
   end

   // Update latches; reset loads the safe pattern so no pad is driven by scan.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bsr_up_q <= SAFE;
      end else if (tap_bus.state == pcbs_pkg::TLR) begin
         bsr_up_q <= SAFE;
      end else if (tap_bus.tck_fall && sel_bsr && tap_bus.state == pcbs_pkg::UPD_DR) begin
         bsr_up_q <= bsr_sh_q;
      end
   end

   // ----------------------------------------
   // Identification and bypass registers.
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         id_sh_q <= {`PCBS_ID_LEN{1'b0}};
      end else if (tap_bus.tck_rise && sel_id) begin
         if (tap_bus.state == pcbs_pkg::CAP_DR) begin
            id_sh_q <= ID_CODE;
         end else if (tap_bus.state == pcbs_pkg::SH_DR) begin
            id_sh_q <= {tap_bus.tdi, id_sh_q[`PCBS_ID_LEN-1:1]};
         end
      end
   end

   // Any instruction without a register of its own selects bypass.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         byp_q <= 1'b0;
      end else if (tap_bus.tck_rise && !sel_bsr && !sel_id) begin
         if (tap_bus.state == pcbs_pkg::CAP_DR) begin
            byp_q <= 1'b0;
         end else if (tap_bus.state == pcbs_pkg::SH_DR) begin
            byp_q <= tap_bus.tdi;
         end
      end
   end

   // ----------------------------------------
   // Data-out, changed on the falling test clock edge.
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tap_bus.tck_fall) begin
         if (tap_bus.state == pcbs_pkg::SH_DR) begin
            tdo <= sel_bsr ? bsr_sh_q[0] : (sel_id ? id_sh_q[0] : byp_q);
            tdo_oe_n <= 1'b0;
         end else if (tap_bus.state == pcbs_pkg::SH_IR) begin
            tdo <= tap_bus.ir_tdo;
            tdo_oe_n <= 1'b0;
         end else begin
            tdo_oe_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Registered pad and core outputs.
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pad_out <= {NP{1'b0}};
         pad_oe_n <= {NP{1'b1}};
         pad_pull0 <= {NP{1'b0}};
      end else begin
         pad_out <= fin_o;
         pad_oe_n <= fin_oe_n;
         pad_pull0 <= pulls;
      end
   end

   // The core always sees the pad, also during a scan test.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_in <= {NP{1'b0}};
      end else begin
         core_in <= pad_lvl;
      end
   end

endmodule

// File: pcbs_top_monitor.sv
`timescale 1ns/100ps
`include "pcbs_regs.svh"

module pcbs_top_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Test port
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   // Configuration and core
   input wire logic configured,
   input wire pcbs_pkg::pcbs_mode_t pin_mode [`PCBS_NUM_IO],
   input wire logic [`PCBS_NUM_PAD-1:0] core_out,
   input wire logic [`PCBS_NUM_PAD-1:0] core_oe_n,
   input wire logic [`PCBS_NUM_PAD-1:0] core_in,
   // Pads
   input wire logic [`PCBS_NUM_PAD-1:0] pad_in,
   input wire logic [`PCBS_NUM_PAD-1:0] pad_out,
   input wire logic [`PCBS_NUM_PAD-1:0] pad_oe_n,
   input wire logic [`PCBS_NUM_PAD-1:0] pad_pull0
);
   // The design releases its own reset two clocks late and registers its pads once more.
   // Checks wait out that tail so the reset values are not judged as normal behaviour.
   logic [2:0] rel_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rel_q <= 3'h0;
      end else begin
         rel_q <= {rel_q[1:0], 1'b1};
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rel_q[2]);

   // ----------------------------------------
   // Test port.
   // ----------------------------------------
   // The data-out pin may only move once a test clock fall has been seen for two samples.
   property p_tdo_after_fall;
      !$stable(tdo) |-> !$past(tck) && !$past(tck, 2);
   endproperty
   a_tdo_after_fall: assert property (p_tdo_after_fall) else $error("tdo moved while tck high");
   property p_oe_after_fall;
      !$stable(tdo_oe_n) |-> !$past(tck) && !$past(tck, 2);
   endproperty
   a_oe_after_fall: assert property (p_oe_after_fall) else $error("tdo_oe_n moved while tck high");

   // ----------------------------------------
   // Pads.
   // ----------------------------------------
   property p_reset_safe;
      disable iff (!resetn) $rose(resetn) |-> (pad_oe_n == 5'h1F && tdo_oe_n)[*2];
   endproperty
   a_reset_safe: assert property (p_reset_safe) else $error("pad driven out of reset");
   property p_pull_off;
      (pad_pull0 & ~pad_oe_n) == 5'h00 && !pad_pull0[4];
   endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull-down on a driven pad");
   // Eight quiet samples cover the synchroniser and the reset tail.
   sequence s_pad_still;
      $stable(pad_in)[*8];
   endsequence
   property p_core_in;
      s_pad_still |-> core_in == pad_in;
   endproperty
   a_core_in: assert property (p_core_in) else $error("core_in does not follow pad");

   for (genvar k = 0; k < `PCBS_NUM_IO; k++) begin : g_pad
      property p_in_off;
         configured && pin_mode[k] == pcbs_pkg::PCBS_INPUT |=> pad_oe_n[k];
      endproperty
      a_in_off: assert property (p_in_off) else $error("input pad driven");
      property p_pin_off;
         configured && pin_mode[k] == pcbs_pkg::PCBS_DIFF_P_IN |=> pad_oe_n[k];
      endproperty
      a_pin_off: assert property (p_pin_off) else $error("differential input pad driven");
      property p_unused;
         !configured || pin_mode[k] == pcbs_pkg::PCBS_UNUSED |=> pad_pull0[k] == pad_oe_n[k];
      endproperty
      a_unused: assert property (p_unused) else $error("unused pad pull wrong");
   end

   for (genvar j = 1; j < `PCBS_NUM_IO; j++) begin : g_pair
      sequence s_n_side;
         configured && pin_mode[j] == pcbs_pkg::PCBS_DIFF_N;
      endsequence
      property p_n_cut;
         s_n_side ##0 pin_mode[j-1] != pcbs_pkg::PCBS_DIFF_P_OUT |=> pad_oe_n[j];
      endproperty
      a_n_cut: assert property (p_n_cut) else $error("N pad driven without partner");
      property p_n_comp;
         s_n_side ##0 pin_mode[j-1] == pcbs_pkg::PCBS_DIFF_P_OUT |=>
            pad_oe_n[j] == pad_oe_n[j-1] && (pad_oe_n[j] || pad_out[j] != pad_out[j-1]);
      endproperty
      a_n_comp: assert property (p_n_comp) else $error("N pad not complement of P");
   end
endmodule

bind pcbs_top pcbs_top_monitor pcbs_top_monitor_inst (
   .clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
   .configured(configured), .pin_mode(pin_mode), .core_out(core_out), .core_oe_n(core_oe_n),
   .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull0(pad_pull0)
);

// File: pcbs_tester_model.sv
`timescale 1ns/100ps

module pcbs_tester_model (
   // Phase reference
   input wire logic clock,
   // Test port
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // ----------------------------------------
   // Test clock steps.
   // ----------------------------------------
   // The clock is parked low between frames; tdo is read late in the high phase, well after
   // the previous fall has moved it, since the port answers some clocks after the pin edge.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #32;
      tck = 1'b1;
      #31;
      q = tdo;
      #1;
      tck = 1'b0;
   endtask

   // No reset pin, so five high mode-select steps bring the port home.
   task automatic tap_reset;
      logic q;
      @(posedge clock);
      #3;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask

   // From idle to shift, n bits LSB first, then update and back to idle.
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = 32'h0000_0000;
      @(posedge clock);
      #3;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule

// File: pcbs_top_tb.sv
`timescale 1ns/100ps
`include "pcbs_regs.svh"

module pcbs_top_tb;
   // Arbitrary identification value; bit zero set.
   localparam logic [31:0] ID_VAL = 32'h1357_9BDF;
   logic clock = 1'b0;
   logic resetn, configured, tck, tms, tdi, tdo, tdo_oe_n;
   pcbs_pkg::pcbs_mode_t pin_mode [`PCBS_NUM_IO];
   logic [4:0] core_out, core_oe_n, core_in, pad_in, pad_out, pad_oe_n, pad_pull0;
   logic [31:0] dout;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;

   pcbs_top #(.ID_CODE(ID_VAL)) pcbs_top_inst (
      .clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .configured(configured), .pin_mode(pin_mode), .core_out(core_out), .core_oe_n(core_oe_n),
      .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull0(pad_pull0)
   );
   pcbs_tester_model pcbs_tester_model_inst (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   always #4 clock = ~clock;

   // ----------------------------------------
   // Checking and closing.
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // The whole run needs under 2000 clocks.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         wrap_up();
      end
   end

   // Boundary vector from per-pad control and output bits; input cells left 0.
   function automatic logic [14:0] pack(input logic [4:0] c, input logic [4:0] o);
      logic [14:0] v;
      v = 15'h0000;
      for (int p = 0; p < 5; p++) begin
         v[3*p] = c[p];
         v[3*p+1] = o[p];
      end
      return v;
   endfunction

   // ----------------------------------------
   // Scenarios.
   // ----------------------------------------
   task automatic t_tap;
      repeat (5) @(posedge clock);
      #1;
      check("pad_oe_n", pad_oe_n, 5'h1F);
      check("tdo_oe_n", tdo_oe_n, 1'b1);
      pcbs_tester_model_inst.tap_reset();
      pcbs_tester_model_inst.scan(1'b0, 32, 32'h0000_0000, dout);
      check("idcode", dout, ID_VAL);
      pcbs_tester_model_inst.scan(1'b1, 5, {27'h0, `PCBS_OP_EXTEST}, dout);
      check("ir capture", dout, {27'h0, `PCBS_IR_CAPTURE});
   endtask

   task automatic t_unconf;
      pcbs_tester_model_inst.scan(1'b0, 15, {17'h0, pack(5'h1F, 5'h1F)}, dout);
      check("oe safe", pad_oe_n, 5'h1F);
      check("pull", pad_pull0, 5'h0F);
      pcbs_tester_model_inst.scan(1'b0, 15, {17'h0, pack(5'h00, 5'h15)}, dout);
      check("oe all", pad_oe_n, 5'h00);
      check("out all", pad_out, 5'h15);
      check("capture", dout, 32'h0000_1A69);
   endtask

   task automatic t_conf;
      @(posedge clock);
      configured <= 1'b1;
      pin_mode[0] <= pcbs_pkg::PCBS_INPUT;
      pin_mode[1] <= pcbs_pkg::PCBS_OUTPUT;
      pin_mode[2] <= pcbs_pkg::PCBS_DIFF_P_OUT;
      pin_mode[3] <= pcbs_pkg::PCBS_DIFF_N;
      core_oe_n <= 5'h00;
      pad_in <= 5'h0D;
      pcbs_tester_model_inst.scan(1'b0, 15, {17'h0, pack(5'h08, 5'h1F)}, dout);
      check("oe", pad_oe_n, 5'h01);
      check("out", pad_out[4:1], 4'hB);
      check("pull", pad_pull0, 5'h00);
      check("core_in", core_in, 5'h0D);
      pcbs_tester_model_inst.scan(1'b0, 16, {16'h0, pack(5'h08, 5'h1F), 1'b1}, dout);
      check("capture", dout[14:0], 15'h0706);
      check("length", dout[15], 1'b1);
   endtask

   task automatic t_mode;
      @(posedge clock);
      pin_mode[2] <= pcbs_pkg::PCBS_DIFF_P_IN;
      repeat (3) @(posedge clock);
      #1;
      check("oe diff in", pad_oe_n, 5'h0D);
   endtask

   initial begin
      resetn = 1'b0;
      configured = 1'b0;
      core_out = 5'h00;
      core_oe_n = 5'h1F;
      pad_in = 5'h0A;
      foreach (pin_mode[i]) pin_mode[i] = pcbs_pkg::PCBS_UNUSED;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      t_tap();
      t_unconf();
      t_conf();
      t_mode();
      wrap_up();
   end
endmodule
